/* inc/sac_pkg.sv */
// shared constants for the converter sequencing and read-out block
package sac_pkg;
	localparam int RES_BITS = 12;
	localparam int CLK_MHZ = 125;
	// conversion time in oscillator ticks and the tick divider
	localparam int CONV_TICKS = 14;
	localparam int OSC_DIV = 8;
	localparam int CONV_NS = 880;
	localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ) / 1000;
	// data shows this many cycles before busy falls
	localparam int DATA_LEAD_CYCLES = 1;
	// track/hold returns to track this many cycles before busy falls
	localparam int TRACK_LEAD_CYCLES = 1;
	// wake-up times per sleep kind
	localparam int WAKE_PARTIAL_NS = 1000;
	localparam int WAKE_FULL_NS = 20000;
	localparam int WAKE_PARTIAL_CYCLES = (WAKE_PARTIAL_NS * CLK_MHZ) / 1000;
	localparam int WAKE_FULL_CYCLES = (WAKE_FULL_NS * CLK_MHZ) / 1000;
	localparam int START_PULSE_NS = 10;
	localparam int ACQ_GAP_NS = 140;
	localparam logic [11:0] RESULT_RST = 12'h000;
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_CONV = 2'b01,
		SAC_SLEEP = 2'b10,
		SAC_WAKE = 2'b11
	} sac_state_t;
endpackage

/* rtl/sac_ctrl.sv */
// conversion sequencing, sleep control and parallel read-out
`timescale 1ns/1ps
// How it works
// - the result bus drives only once both chip select and read strobe are low.
// - chip select and read strobe meet in one AND, so either may gate the read.
// - with both selects held low the bus stays driven and new data lands before busy falls.
// - a falling start edge puts the track/hold into hold and starts conversion together.
// - if start is still low at end of conversion the block sleeps at busy's fall.
// - the sleep kind select picks partial sleep (reference, oscillator on) or full sleep.
// - a sleeping block wakes on the next rising start edge, after a kind-dependent delay.
// - busy rises after the start fall and stays high for the whole conversion.
// - busy falls only after the result is in the output register.
// - the track/hold goes back to track just before busy falls; acquisition starts at the fall.
// - a start fall while busy aborts and restarts the conversion.
// - the bus returns to high impedance three clock edges after either select goes high.
module sac_ctrl #(
	parameter int BITS = sac_pkg::RES_BITS,
	parameter int CONV_TICKS = sac_pkg::CONV_TICKS,
	parameter int OSC_DIV = sac_pkg::OSC_DIV,
	parameter int WAKE_FULL = sac_pkg::WAKE_FULL_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// conversion control pins
	input wire logic start_sample_n,
	input wire logic sleep_kind_select,
	output logic busy,
	// read pins
	input wire logic chip_sel_n,
	input wire logic read_n,
	output logic [BITS-1:0] result_bus_o,
	output logic result_bus_oe,
	// analog side
	input wire logic cmp_hi,
	output logic hold,
	output logic trial_valid,
	output logic [BITS-1:0] trial_code,
	output logic ref_osc_pd,
	output logic analog_pd
);
	localparam int TCW = $clog2(CONV_TICKS + 2);
	localparam int DVW = $clog2(OSC_DIV + 1);
	// the wake counter must hold the longer of the two wake delays, whichever it is
	localparam int WAKE_MAX = (WAKE_FULL > sac_pkg::WAKE_PARTIAL_CYCLES) ? WAKE_FULL : sac_pkg::WAKE_PARTIAL_CYCLES;
	localparam int WKW = $clog2(WAKE_MAX + 2);

	// =====================================================
	// pin synchronisers
	// a start low shorter than about one clock period can fall between samples;
	// an asynchronous capture flop would catch it but brings a second timing domain,
	// so the host keeps start low for at least two cycles
	logic start_n_s;
	logic kind_s;
	logic cs_s;
	logic rd_s;
	sac_sync #(.W(1), .RST_VAL(1'b1)) u_sync_start (
		.sys_clk(sys_clk),
		.rst(rst),
		.d(start_sample_n),
		.q(start_n_s)
	);
	sac_sync #(.W(3), .RST_VAL(3'b011)) u_sync_misc (
		.sys_clk(sys_clk),
		.rst(rst),
		.d({sleep_kind_select, chip_sel_n, read_n}),
		.q({kind_s, cs_s, rd_s})
	);

	// =====================================================
	// edge detection
	logic start_n_d_r;
	logic start_fall;
	logic start_rise;
	// the delay flop resets to the idle high level of the pin, so no false edge follows reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_n_d_r <= 1'b1;
		end else begin
			start_n_d_r <= start_n_s;
		end
	end
	assign start_fall = start_n_d_r & ~start_n_s;
	assign start_rise = ~start_n_d_r & start_n_s;

	// =====================================================
	// internal oscillator: one-cycle tick enable
	logic [DVW-1:0] div_r;
	logic tick;
	logic osc_run;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
		end else if (!osc_run || start_fall) begin
			div_r <= '0;
		end else if (div_r == DVW'(OSC_DIV - 1)) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end
	assign tick = osc_run && (div_r == DVW'(OSC_DIV - 1));

	// =====================================================
	// state machine
	sac_pkg::sac_state_t state_r;
	sac_pkg::sac_state_t state_nxt;
	logic [TCW-1:0] tcnt_r;
	logic [WKW-1:0] wcnt_r;
	logic full_sleep_r;
	logic sar_done;
	logic sar_fin_r;
	logic conv_end;
	logic can_start;

	// starts are ignored while asleep or waking; only idle and converting take one
	assign can_start = (state_r == sac_pkg::SAC_IDLE) || (state_r == sac_pkg::SAC_CONV);
	// conversion ends after the set tick count, once the SAR has its final bit
	assign conv_end = (state_r == sac_pkg::SAC_CONV) && tick && sar_fin_r
		&& (tcnt_r == TCW'(CONV_TICKS - 1));

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			sac_pkg::SAC_IDLE: begin
				if (start_fall) begin
					state_nxt = sac_pkg::SAC_CONV;
				end
			end
			sac_pkg::SAC_CONV: begin
				if (start_fall) begin
					state_nxt = sac_pkg::SAC_CONV;
				end else if (conv_end) begin
					state_nxt = start_n_s ? sac_pkg::SAC_IDLE : sac_pkg::SAC_SLEEP;
				end
			end
			sac_pkg::SAC_SLEEP: begin
				if (start_rise) begin
					state_nxt = sac_pkg::SAC_WAKE;
				end
			end
			sac_pkg::SAC_WAKE: begin
				if (wcnt_r == '0) begin
					state_nxt = sac_pkg::SAC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= sac_pkg::SAC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// conversion tick counter, cleared on every start so a restart begins fresh
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tcnt_r <= '0;
		end else if (start_fall && can_start) begin
			tcnt_r <= '0;
		end else if (state_r == sac_pkg::SAC_CONV && tick && tcnt_r != TCW'(CONV_TICKS - 1)) begin
			tcnt_r <= tcnt_r + 1'b1;
		end
	end

	// sleep kind is latched at sleep entry; the pin is expected to be static
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			full_sleep_r <= 1'b0;
		end else if (conv_end && !start_n_s) begin
			full_sleep_r <= ~kind_s;
		end
	end

	// full sleep needs far longer to bring the analog circuitry back than partial sleep
	logic [WKW-1:0] wake_len;
	assign wake_len = full_sleep_r ? WKW'(WAKE_FULL - 1) : WKW'(sac_pkg::WAKE_PARTIAL_CYCLES - 1);
	// wake-up delay counter
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wcnt_r <= '0;
		end else if (state_r == sac_pkg::SAC_SLEEP && start_rise) begin
			wcnt_r <= wake_len;
		end else if (wcnt_r != '0) begin
			wcnt_r <= wcnt_r - 1'b1;
		end
	end

	assign osc_run = (state_r == sac_pkg::SAC_CONV);
	// power-down follows the registered state, so it lands on the edge where busy falls
	// and never while busy is still high
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			analog_pd <= 1'b0;
		end else begin
			analog_pd <= (state_r == sac_pkg::SAC_SLEEP);
		end
	end
	// partial sleep keeps reference and oscillator up; only full sleep drops them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ref_osc_pd <= 1'b0;
		end else begin
			ref_osc_pd <= (state_r == sac_pkg::SAC_SLEEP) && full_sleep_r;
		end
	end

	// =====================================================
	// successive approximation
	logic [BITS-1:0] trial;
	sac_sar #(.BITS(BITS)) u_sar (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(start_fall && can_start),
		.tick(tick && state_r == sac_pkg::SAC_CONV),
		.cmp_hi(cmp_hi),
		.trial(trial),
		.done(sar_done)
	);
	assign trial_code = trial;
	assign trial_valid = (state_r == sac_pkg::SAC_CONV);

	// =====================================================
	// result register, busy and track/hold
	// the result is loaded one cycle ahead of busy falling, so a bus held open
	// shows the new code slightly before the edge
	logic [BITS-1:0] result_r;
	logic load_pend_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result_r <= sac_pkg::RESULT_RST;
		end else if (conv_end && !start_fall) begin
			result_r <= trial;
		end
	end
	// busy is released one cycle after the load, once the register holds the new code
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			load_pend_r <= 1'b0;
		end else begin
			load_pend_r <= conv_end && !start_fall;
		end
	end
	// the tick count alone cannot end a conversion before the last bit is decided;
	// a restart drops a finish that belongs to the aborted conversion
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sar_fin_r <= 1'b0;
		end else if (start_fall && can_start) begin
			sar_fin_r <= 1'b0;
		end else if (sar_done) begin
			sar_fin_r <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else if (start_fall && can_start) begin
			// a restart wins over a pending release, so busy stays high across it
			busy <= 1'b1;
		end else if (load_pend_r) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold <= 1'b0;
		end else if (start_fall && can_start) begin
			hold <= 1'b1;
		end else if (conv_end) begin
			hold <= 1'b0;
		end
	end

	// =====================================================
	// parallel read-out
	logic rd_en;
	assign rd_en = ~(cs_s | rd_s);
	// the enable sees the selects three edges late, the cost of synchronising them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result_bus_oe <= 1'b0;
		end else begin
			result_bus_oe <= rd_en;
		end
	end
	// the new code bypasses the result register so an open bus shows it before busy falls
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result_bus_o <= sac_pkg::RESULT_RST;
		end else if (conv_end && !start_fall) begin
			result_bus_o <= trial;
		end else begin
			result_bus_o <= result_r;
		end
	end
endmodule

/* rtl/sac_sar.sv */
// successive-approximation engine: one bit decided per oscillator tick
`timescale 1ns/1ps
module sac_sar #(
	parameter int BITS = 12
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control
	input wire logic start,
	input wire logic tick,
	input wire logic cmp_hi,
	// result
	output logic [BITS-1:0] trial,
	output logic done
);
	logic [BITS-1:0] mask_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trial <= '0;
			mask_r <= '0;
			done <= 1'b0;
		end else if (start) begin
			trial <= {1'b1, {(BITS-1){1'b0}}};
			mask_r <= {1'b1, {(BITS-1){1'b0}}};
			done <= 1'b0;
		end else if (tick && mask_r != '0) begin
			// keep the trial bit when the held sample is at or above the trial code
			trial <= (cmp_hi ? trial : (trial & ~mask_r)) | (mask_r >> 1);
			mask_r <= mask_r >> 1;
			done <= (mask_r == {{(BITS-1){1'b0}}, 1'b1});
		end else begin
			done <= 1'b0;
		end
	end
endmodule

/* rtl/sac_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sac_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

/* testbench/sac_ctrl_sva.sv */
// checker for conversion sequencing, sleep entry and read-out
`timescale 1ns/1ps
module sac_ctrl_sva #(
	parameter int BITS = 12,
	parameter int CONV_TICKS = 14,
	parameter int OSC_DIV = 8,
	parameter int WAKE_FULL = 2500
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// conversion pins
	input wire logic start_sample_n,
	input wire logic sleep_kind_select,
	input wire logic busy,
	// read pins
	input wire logic chip_sel_n,
	input wire logic read_n,
	input wire logic [BITS-1:0] result_bus_o,
	input wire logic result_bus_oe,
	// analog side
	input wire logic cmp_hi,
	input wire logic hold,
	input wire logic trial_valid,
	input wire logic [BITS-1:0] trial_code,
	input wire logic ref_osc_pd,
	input wire logic analog_pd
);
	localparam int CONV = CONV_TICKS * OSC_DIV;
	int bcnt;
	// =====================
	// busy length counter
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bcnt <= 0;
		end else begin
			bcnt <= busy ? bcnt + 1 : 0;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// selects need four samples to pass the synchroniser
	sequence sel_low4;
		(!chip_sel_n && !read_n) [*4];
	endsequence
	sequence sel_high4;
		(chip_sel_n || read_n) [*4];
	endsequence
	sequence conv_end;
		$fell(busy);
	endsequence
	sel_gates_bus_a: assert property (sel_low4 |-> result_bus_oe) else $error("bus idle with both selects low");
	sel_release_a: assert property (sel_high4 |-> !result_bus_oe) else $error("bus driven with a select high");
	hold_at_start_a: assert property ($rose(busy) |-> hold) else $error("busy rose without hold");
	busy_span_a: assert property (conv_end |-> bcnt >= CONV) else $error("busy shorter than a conversion");
	track_lead_a: assert property (conv_end |-> $past(hold, 2) && !$past(hold)) else $error("track not one cycle early");
	data_lead_a: assert property (conv_end |-> $stable(result_bus_o)) else $error("result changed at busy fall");
	sequence start_held;
		!start_sample_n && !$past(start_sample_n, 3);
	endsequence
	sleep_entry_a: assert property (conv_end ##0 start_held |-> ##[0:2] analog_pd)
		else $error("no sleep with start low");
	sleep_kind_a: assert property (analog_pd |-> ref_osc_pd == !sleep_kind_select) else $error("wrong sleep kind");
	quiet_sleep_a: assert property (analog_pd |-> !busy) else $error("busy while asleep");
	trial_init_a: assert property ($rose(busy) |-> trial_valid && trial_code == {1'b1, {(BITS-1){1'b0}}})
		else $error("conversion not started from the top trial bit");
endmodule
bind sac_ctrl sac_ctrl_sva #(.BITS(BITS), .CONV_TICKS(CONV_TICKS), .OSC_DIV(OSC_DIV), .WAKE_FULL(WAKE_FULL)) chk_u (
	.sys_clk(sys_clk), .rst(rst), .start_sample_n(start_sample_n), .sleep_kind_select(sleep_kind_select),
	.busy(busy), .chip_sel_n(chip_sel_n), .read_n(read_n), .result_bus_o(result_bus_o),
	.result_bus_oe(result_bus_oe), .cmp_hi(cmp_hi), .hold(hold), .trial_valid(trial_valid),
	.trial_code(trial_code), .ref_osc_pd(ref_osc_pd), .analog_pd(analog_pd));

/* testbench/sac_ctrl_tb.sv */
// self-checking bench for the converter sequencing block
`timescale 1ns/1ps
module sac_ctrl_tb;
	localparam int CONV = sac_pkg::CONV_TICKS * 2;
	logic sys_clk, rst, kind, busy, oe, hold, tv, rpd, apd, cmp, sn, cs, rd;
	logic [11:0] bus, trial, sample;
	logic [11:0] vals [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h800};
	int n_mismatch, n_tests;
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	sac_host_model host_u (.sys_clk(sys_clk), .trial_code(trial), .result_bus_o(bus), .result_bus_oe(oe),
		.sample(sample), .start_sample_n(sn), .chip_sel_n(cs), .read_n(rd), .cmp_hi(cmp));
	sac_ctrl #(.OSC_DIV(2), .WAKE_FULL(20)) dut_u (.sys_clk(sys_clk), .rst(rst), .start_sample_n(sn),
		.sleep_kind_select(kind), .busy(busy), .chip_sel_n(cs), .read_n(rd), .result_bus_o(bus),
		.result_bus_oe(oe), .cmp_hi(cmp), .hold(hold), .trial_valid(tv), .trial_code(trial),
		.ref_osc_pd(rpd), .analog_pd(apd));
	// =====================
	// checking helpers
	task chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wait_busy(input logic v, output int n);
		n = 0;
		while (busy !== v) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 400) begin
				chk({11'h0, busy}, {11'h0, v});
				complete_run;
			end
		end
	endtask
	// =====================
	// scenarios
	task conv(input logic [11:0] s, input int low, input logic held, input int extra);
		int n;
		logic [11:0] d;
		@(posedge sys_clk);
		sample <= s;
		fork
			host_u.start(low);
		join_none
		wait_busy(1'b1, n);
		chk({11'h0, hold}, 12'h1);
		if (extra > 0) begin
			repeat (extra) @(posedge sys_clk);
			sample <= ~s;
			host_u.start(2);
			s = ~s;
		end
		wait_busy(1'b0, n);
		// counted from the last start taken, so a restart must show a whole conversion after it
		chk(12'(n >= CONV && n <= CONV + 3), 12'h1);
		if (held) begin
			chk(bus, s);
			chk({11'h0, oe}, 12'h1);
		end else begin
			repeat (18) @(posedge sys_clk);
			host_u.read(d);
			chk(d, s);
		end
	endtask
	task sleep_run(input logic k);
		@(posedge sys_clk);
		kind <= k;
		conv(12'h5a5, CONV + 30, 1'b0, 0);
		#1;
		chk({11'h0, apd}, 12'h1);
		chk({11'h0, rpd}, {11'h0, ~k});
		repeat (10) @(posedge sys_clk);
		#1;
		for (int i = 0; i < 300 && apd !== 1'b0; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({11'h0, apd}, 12'h0);
		// a start while still waking up is refused
		host_u.start(2);
		repeat (8) @(posedge sys_clk);
		#1;
		chk({11'h0, busy}, 12'h0);
		repeat (130) @(posedge sys_clk);
		conv(12'h1e3, 2, 1'b0, 0);
	endtask
	initial begin
		rst = 1'b1;
		kind = 1'b1;
		sample = 12'h000;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({busy, hold, oe, apd, bus[7:0]}, 12'h000);
		@(posedge sys_clk);
		rst <= 1'b0;
		foreach (vals[i]) conv(vals[i], 2, 1'b0, 0);
		conv(12'h36c, 2, 1'b0, 6);
		host_u.sel(1'b0);
		conv(12'h3c7, 2, 1'b1, 0);
		host_u.sel(1'b1);
		repeat (4) @(posedge sys_clk);
		#1;
		chk({11'h0, oe}, 12'h0);
		sleep_run(1'b1);
		sleep_run(1'b0);
		complete_run;
	end
endmodule

/* testbench/sac_host_model.sv */
// host processor and comparator model facing the converter block
`timescale 1ns/1ps
module sac_host_model (
	// clock
	input wire logic sys_clk,
	// from the block
	input wire logic [11:0] trial_code,
	input wire logic [11:0] result_bus_o,
	input wire logic result_bus_oe,
	// analog input level
	input wire logic [11:0] sample,
	// to the block
	output logic start_sample_n,
	output logic chip_sel_n,
	output logic read_n,
	output logic cmp_hi
);
	// =====================
	// ideal comparator, straight binary
	assign cmp_hi = sample >= trial_code;
	initial begin
		start_sample_n = 1'b1;
		chip_sel_n = 1'b1;
		read_n = 1'b1;
	end
	// low time of one cycle is the shortest the synchroniser sees
	task start(input int low);
		@(posedge sys_clk);
		start_sample_n <= 1'b0;
		repeat (low) @(posedge sys_clk);
		start_sample_n <= 1'b1;
	endtask
	task sel(input logic v);
		@(posedge sys_clk);
		chip_sel_n <= v;
		read_n <= v;
	endtask
	// called only when no conversion runs; an undriven bus reads as unknown
	task read(output logic [11:0] d);
		int i;
		sel(1'b0);
		for (i = 0; i < 8 && result_bus_oe !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		d = (result_bus_oe === 1'b1) ? result_bus_o : 12'hxxx;
		sel(1'b1);
	endtask
endmodule
